// ### spc_core.sv
// Scaling, parameter update policy, serial-link settings and panel security core.
`timescale 1ns/10ps
module spc_core #(
  parameter int SEC_CYCLES = spc_pkg::CLK_HZ,
  parameter int CNT_W = 32,
  parameter logic [15:0] RECOVERY_CODE = 16'h1234 // Arbitrary value.
) (
  input wire logic I_CORE_CLK,
  input wire logic I_ARST_N,
  input wire logic I_PULSE_UP,
  input wire logic I_PULSE_DN,
  input wire logic I_ZERO,
  input wire logic I_POLICY_DEFER,
  input wire logic I_EDIT_WE,
  input wire logic [2:0] I_EDIT_SEL,
  input wire logic signed [20:0] I_EDIT_VAL,
  input wire logic I_ADDR_WE,
  input wire logic [7:0] I_ADDR_VAL,
  input wire logic I_FRAME_VALID,
  input wire logic [7:0] I_FRAME_ADDR,
  input wire logic [2:0] I_BAUD_SEL,
  input wire logic I_RW_GATE,
  input wire logic I_RW_REQ,
  input wire logic [7:0] I_RW_REG,
  input wire logic [6:0] I_GAP_LIMIT,
  input wire logic [2:0] I_REPLY_SEL,
  input wire logic I_REQ_END,
  input wire logic I_CODE_WE,
  input wire logic I_CODE_TRY,
  input wire logic I_RESTORE_TRY,
  input wire logic [15:0] I_CODE_VAL,
  input wire logic I_MENU_EXIT,
  input wire logic [3:0] I_THR_PERMIT,
  input wire logic I_OFS_PERMIT,
  input wire logic I_BRIGHT_WE,
  input wire logic [3:0] I_BRIGHT_VAL,
  input wire logic I_AUTO_SEL,
  input wire logic I_AUTO_DONE,
  input wire logic I_KEY_ENTER,
  input wire logic I_KEY_ESC,
  output logic signed [55:0] O_RESULT,
  output logic [20:0] O_PRECOUNT,
  output logic signed [CNT_W-1:0] O_MAINCOUNT,
  output logic [2:0] O_POINT,
  output logic [83:0] O_THRESH,
  output logic O_EDIT_REJ,
  output logic [7:0] O_ADDR,
  output logic O_ADDR_HIT,
  output logic [16:0] O_BIT_CYCLES,
  output logic O_RW_ALLOW,
  output logic O_GAP_TIMEOUT,
  output logic O_REPLY_GO,
  output logic O_MENU_OK,
  output logic O_UNLOCKED,
  output logic O_RECOVERY_USED,
  output logic [3:0] O_THR_EDIT_OK,
  output logic O_OFS_EDIT_OK,
  output logic O_QUICKVIEW_ALT,
  output logic [3:0] O_BRIGHT,
  output logic O_AUTO_ASK,
  output logic O_AUTO_RUN,
  output logic O_RESTORE_ASK,
  output logic O_RESTORE
);
  // The result path is 56 bits wide, which bounds the main counter width.
  if (CNT_W < 22 || CNT_W > 35 || SEC_CYCLES < 1) begin : g_bad_params
    $error("spc_core: bad parameters");
  end

  function automatic logic edit_ok(input logic [2:0] s, input logic signed [20:0] v);
    logic in_rng;
    in_rng = (v >= spc_pkg::VAL_MIN) && (v <= spc_pkg::VAL_MAX);
    case (s)
      spc_pkg::SEL_MULT: edit_ok = in_rng && (v != 21'sd0);
      spc_pkg::SEL_DEN: edit_ok = (v >= 21'sd1) && (v <= spc_pkg::VAL_MAX);
      spc_pkg::SEL_POINT: edit_ok = (v >= 21'sd0) && (v <= spc_pkg::POINT_MAX);
      default: edit_ok = in_rng;
    endcase
  endfunction : edit_ok

  // Cycles per bit at each line rate, rounded down.
  function automatic logic [16:0] bit_cycles(input logic [2:0] s);
    int rate;
    case (s)
      3'h0: rate = 1200;
      3'h1: rate = 2400;
      3'h2: rate = 4800;
      3'h3: rate = 9600;
      3'h4: rate = 19200;
      3'h5: rate = 38400;
      3'h6: rate = 57600;
      default: rate = 115200;
    endcase
    bit_cycles = 17'(spc_pkg::CLK_HZ / rate);
  endfunction : bit_cycles

  function automatic logic [7:0] reply_chars(input logic [2:0] s);
    case (s)
      3'h1: reply_chars = 8'd10;
      3'h2: reply_chars = 8'd20;
      3'h3: reply_chars = 8'd50;
      3'h4: reply_chars = 8'd100;
      3'h5: reply_chars = 8'd200;
      default: reply_chars = 8'd0;
    endcase
  endfunction : reply_chars

  logic signed [20:0] shadow_reg [8];
  logic signed [20:0] work_reg [8];
  logic signed [20:0] shadow_next [8];
  logic edit_valid;
  logic restore_fire;
  spc_pkg::spc_state_t state_reg;

  assign edit_valid = I_EDIT_WE && edit_ok(I_EDIT_SEL, I_EDIT_VAL);
  assign restore_fire = (state_reg == spc_pkg::ST_DEF_ASK) && I_KEY_ENTER;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      shadow_next[i] = shadow_reg[i];
    end
    if (edit_valid) begin
      shadow_next[I_EDIT_SEL] = I_EDIT_VAL;
    end
  end

  // Shadow takes every valid edit unless a restore fires; the working set follows it at once or on zeroing.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < 8; i++) begin
        shadow_reg[i] <= '0;
        work_reg[i] <= '0;
      end
      shadow_reg[0] <= spc_pkg::MULT_RST;
      shadow_reg[1] <= spc_pkg::DEN_RST;
      work_reg[0] <= spc_pkg::MULT_RST;
      work_reg[1] <= spc_pkg::DEN_RST;
    end else if (restore_fire) begin
      for (int i = 0; i < 8; i++) begin
        shadow_reg[i] <= '0;
        work_reg[i] <= '0;
      end
      shadow_reg[0] <= spc_pkg::MULT_RST;
      shadow_reg[1] <= spc_pkg::DEN_RST;
      work_reg[0] <= spc_pkg::MULT_RST;
      work_reg[1] <= spc_pkg::DEN_RST;
    end else begin
      shadow_reg <= shadow_next;
      if (!I_POLICY_DEFER || I_ZERO) begin
        work_reg <= shadow_next;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_EDIT_REJ <= 1'b0;
    end else begin
      O_EDIT_REJ <= I_EDIT_WE && !edit_ok(I_EDIT_SEL, I_EDIT_VAL);
    end
  end

  // Raw pulse counters; a shrunken modulus wraps at the next pulse.
  logic [20:0] den_u;
  assign den_u = 21'(work_reg[1]);
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PRECOUNT <= '0;
      O_MAINCOUNT <= '0;
    end else if (I_ZERO || restore_fire) begin
      O_PRECOUNT <= '0;
      O_MAINCOUNT <= '0;
    end else if (I_PULSE_UP && !I_PULSE_DN) begin
      if (O_PRECOUNT + 21'd1 >= den_u) begin
        O_PRECOUNT <= '0;
        O_MAINCOUNT <= O_MAINCOUNT + 1'b1;
      end else begin
        O_PRECOUNT <= O_PRECOUNT + 21'd1;
      end
    end else if (I_PULSE_DN && !I_PULSE_UP) begin
      if (O_PRECOUNT == 21'd0 || O_PRECOUNT >= den_u) begin
        O_PRECOUNT <= den_u - 21'd1;
        O_MAINCOUNT <= O_MAINCOUNT - 1'b1;
      end else begin
        O_PRECOUNT <= O_PRECOUNT - 21'd1;
      end
    end
  end

  // Signed division truncates toward zero, so negative inexact quotients step down.
  logic signed [42:0] frac_num;
  logic signed [42:0] frac_q;
  logic signed [42:0] den_s;
  always_comb begin
    den_s = 43'(work_reg[1]);
    frac_num = $signed({22'd0, O_PRECOUNT}) * 43'(work_reg[0]);
    frac_q = frac_num / den_s;
    if (frac_num < 0 && frac_q * den_s != frac_num) begin
      frac_q = frac_q - 43'sd1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RESULT <= '0;
    end else begin
      O_RESULT <= 56'(O_MAINCOUNT) * 56'(work_reg[0]) + 56'(frac_q)
        + 56'(work_reg[2]);
    end
  end

  assign O_POINT = work_reg[3][2:0];
  assign O_THRESH = {work_reg[7], work_reg[6], work_reg[5], work_reg[4]};

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ADDR <= spc_pkg::ADDR_RST;
      O_ADDR_HIT <= 1'b0;
      O_BIT_CYCLES <= '0;
      O_RW_ALLOW <= 1'b0;
    end else begin
      if (I_ADDR_WE && I_ADDR_VAL <= spc_pkg::ADDR_MAX) begin
        O_ADDR <= I_ADDR_VAL;
      end
      O_ADDR_HIT <= I_FRAME_VALID && (I_FRAME_ADDR ==
        ((O_ADDR == 8'h00) ? spc_pkg::ADDR_BCAST : O_ADDR));
      O_BIT_CYCLES <= bit_cycles(I_BAUD_SEL);
      O_RW_ALLOW <= I_RW_REQ && (I_RW_GATE || (I_RW_REG >= spc_pkg::GATE_LO
        && I_RW_REG <= spc_pkg::GATE_HI));
    end
  end

  // Frame gap supervision in whole seconds; any received frame restarts it.
  logic [31:0] sec_cnt_reg;
  logic [6:0] gap_sec_reg;
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sec_cnt_reg <= '0;
      gap_sec_reg <= '0;
      O_GAP_TIMEOUT <= 1'b0;
    end else if (I_FRAME_VALID || I_GAP_LIMIT == 7'd0 || I_GAP_LIMIT > spc_pkg::GAP_MAX) begin
      sec_cnt_reg <= '0;
      gap_sec_reg <= '0;
      O_GAP_TIMEOUT <= 1'b0;
    end else if (gap_sec_reg >= I_GAP_LIMIT) begin
      O_GAP_TIMEOUT <= 1'b1;
    end else if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
      sec_cnt_reg <= '0;
      gap_sec_reg <= gap_sec_reg + 7'd1;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'd1;
    end
  end

  // Reply delay counted in whole characters of eleven bit times.
  logic [16:0] rb_cyc_reg;
  logic [3:0] rb_bit_reg;
  logic [7:0] rb_chr_reg;
  logic rb_busy_reg;
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rb_cyc_reg <= '0;
      rb_bit_reg <= '0;
      rb_chr_reg <= '0;
      rb_busy_reg <= 1'b0;
      O_REPLY_GO <= 1'b0;
    end else begin
      O_REPLY_GO <= 1'b0;
      if (I_REQ_END) begin
        rb_cyc_reg <= '0;
        rb_bit_reg <= '0;
        rb_chr_reg <= reply_chars(I_REPLY_SEL);
        rb_busy_reg <= reply_chars(I_REPLY_SEL) != 8'd0;
        O_REPLY_GO <= reply_chars(I_REPLY_SEL) == 8'd0;
      end else if (rb_busy_reg) begin
        if (rb_cyc_reg + 17'd1 < O_BIT_CYCLES) begin
          rb_cyc_reg <= rb_cyc_reg + 17'd1;
        end else begin
          rb_cyc_reg <= '0;
          if (rb_bit_reg + 4'd1 < spc_pkg::CHAR_BITS) begin
            rb_bit_reg <= rb_bit_reg + 4'd1;
          end else begin
            rb_bit_reg <= '0;
            rb_chr_reg <= rb_chr_reg - 8'd1;
            if (rb_chr_reg == 8'd1) begin
              rb_busy_reg <= 1'b0;
              O_REPLY_GO <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Passcode, recovery code, edit permits and brightness.
  logic [15:0] code_reg;
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      code_reg <= spc_pkg::CODE_OFF;
      O_RECOVERY_USED <= 1'b0;
      O_MENU_OK <= 1'b0;
      O_UNLOCKED <= 1'b0;
      O_BRIGHT <= spc_pkg::BRIGHT_RST;
    end else begin
      O_MENU_OK <= 1'b0;
      if (restore_fire) begin
        code_reg <= spc_pkg::CODE_OFF;
        O_BRIGHT <= spc_pkg::BRIGHT_RST;
      end else if (I_CODE_TRY && !O_RECOVERY_USED && I_CODE_VAL == RECOVERY_CODE) begin
        code_reg <= spc_pkg::CODE_OFF;
        O_RECOVERY_USED <= 1'b1;
      end else if (I_CODE_WE && O_UNLOCKED) begin
        code_reg <= I_CODE_VAL;
      end
      if (I_CODE_TRY) begin
        O_MENU_OK <= code_reg == spc_pkg::CODE_OFF || I_CODE_VAL == code_reg
          || (!O_RECOVERY_USED && I_CODE_VAL == RECOVERY_CODE);
      end
      // An accepted attempt beats a menu exit in the same cycle.
      if (O_MENU_OK) begin
        O_UNLOCKED <= 1'b1;
      end else if (I_MENU_EXIT) begin
        O_UNLOCKED <= 1'b0;
      end
      if (I_BRIGHT_WE && I_BRIGHT_VAL >= spc_pkg::BRIGHT_MIN
          && I_BRIGHT_VAL <= spc_pkg::BRIGHT_MAX) begin
        O_BRIGHT <= I_BRIGHT_VAL;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_THR_EDIT_OK <= '0;
      O_OFS_EDIT_OK <= 1'b0;
      O_QUICKVIEW_ALT <= 1'b0;
    end else begin
      O_THR_EDIT_OK <= I_THR_PERMIT | {4{O_UNLOCKED}};
      O_OFS_EDIT_OK <= I_OFS_PERMIT || O_UNLOCKED;
      O_QUICKVIEW_ALT <= I_OFS_PERMIT;
    end
  end

  // Confirmation dialogs for auto scaling and factory restore.
  spc_pkg::spc_state_t state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      spc_pkg::ST_IDLE: begin
        if (I_AUTO_SEL) begin
          state_next = spc_pkg::ST_AUTO_ASK;
        end else if (I_RESTORE_TRY && I_CODE_VAL == spc_pkg::RESTORE_CODE) begin
          state_next = spc_pkg::ST_DEF_ASK;
        end
      end
      spc_pkg::ST_AUTO_ASK: begin
        if (I_KEY_ESC) begin
          state_next = spc_pkg::ST_IDLE;
        end else if (I_KEY_ENTER) begin
          state_next = spc_pkg::ST_AUTO_RUN;
        end
      end
      spc_pkg::ST_AUTO_RUN: begin
        if (I_KEY_ESC || I_AUTO_DONE) begin
          state_next = spc_pkg::ST_IDLE;
        end
      end
      spc_pkg::ST_DEF_ASK: begin
        if (I_KEY_ESC || I_KEY_ENTER) begin
          state_next = spc_pkg::ST_IDLE;
        end
      end
      default: state_next = spc_pkg::ST_IDLE;
    endcase
  end

  // Dialog flags are decoded from the next state and the restore pulse from restore_fire, so the ports leave straight from flip-flops.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg <= spc_pkg::ST_IDLE;
      O_AUTO_ASK <= 1'b0;
      O_AUTO_RUN <= 1'b0;
      O_RESTORE_ASK <= 1'b0;
      O_RESTORE <= 1'b0;
    end else begin
      state_reg <= state_next;
      O_AUTO_ASK <= state_next == spc_pkg::ST_AUTO_ASK;
      O_AUTO_RUN <= state_next == spc_pkg::ST_AUTO_RUN;
      O_RESTORE_ASK <= state_next == spc_pkg::ST_DEF_ASK;
      O_RESTORE <= restore_fire;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);

  a_mult_zero_rej: assert property (I_EDIT_WE && I_EDIT_SEL == spc_pkg::SEL_MULT
    && I_EDIT_VAL == 21'sd0 |=> O_EDIT_REJ && $stable(work_reg[0]))
    else $error("zero multiplier accepted");
  a_den_zero_rej: assert property (I_EDIT_WE && I_EDIT_SEL == spc_pkg::SEL_DEN
    && I_EDIT_VAL == 21'sd0 |=> O_EDIT_REJ && work_reg[1] != 21'sd0)
    else $error("zero denominator accepted");
  a_imm_apply: assert property (!I_POLICY_DEFER && edit_valid && !restore_fire
    |=> work_reg[$past(I_EDIT_SEL)] == $past(I_EDIT_VAL))
    else $error("immediate edit not applied");
  a_defer_hold: assert property (I_POLICY_DEFER && !I_ZERO && !restore_fire
    |=> $stable(work_reg[0]) && $stable(work_reg[2]))
    else $error("deferred edit applied early");
  a_zero_copy: assert property (I_POLICY_DEFER && I_ZERO && !edit_valid && !restore_fire
    |=> work_reg[2] == $past(shadow_reg[2]) && O_MAINCOUNT == '0)
    else $error("shadow not copied on zeroing");
  a_pre_bound: assert property (I_PULSE_UP && !I_PULSE_DN && !I_ZERO
    && !restore_fire && O_PRECOUNT + 21'd1 == den_u |=> O_PRECOUNT == '0
    && O_MAINCOUNT == $past(O_MAINCOUNT) + 1'b1)
    else $error("precounter overflow did not step main counter");
  a_addr_bcast: assert property (I_FRAME_VALID && O_ADDR == 8'h00
    && I_FRAME_ADDR == 8'hff |=> O_ADDR_HIT)
    else $error("address 0 did not answer 255");
  a_gate_pass: assert property (I_RW_REQ && I_RW_REG >= 8'h04 && I_RW_REG <= 8'h08
    |=> O_RW_ALLOW)
    else $error("gate blocked counter registers");
  a_gate_block: assert property (I_RW_REQ && !I_RW_GATE && I_RW_REG > 8'h08
    |=> !O_RW_ALLOW)
    else $error("gate let a configuration write pass");
  a_code_off: assert property (I_CODE_TRY && code_reg == 16'h0000 |=> O_MENU_OK)
    else $error("cleared passcode still checked");
  a_recov_once: assert property (O_RECOVERY_USED && I_CODE_TRY
    && I_CODE_VAL == RECOVERY_CODE && code_reg != spc_pkg::CODE_OFF
    && code_reg != RECOVERY_CODE |=> !O_MENU_OK)
    else $error("recovery code became reusable");
  a_auto_confirm: assert property (state_reg == spc_pkg::ST_IDLE && I_AUTO_SEL
    ##1 !I_KEY_ENTER && !I_KEY_ESC |=> O_AUTO_ASK && !O_AUTO_RUN)
    else $error("auto scaling started without confirmation");
  a_restore_fire: assert property (O_RESTORE_ASK && I_KEY_ENTER
    |=> O_RESTORE ##1 !O_RESTORE)
    else $error("restore not confirmed by enter");
  a_bright_range: assert property (O_BRIGHT >= 4'h1 && O_BRIGHT <= 4'h8)
    else $error("brightness out of range");

  c_deferred_zero: cover property (I_POLICY_DEFER && edit_valid ##[1:20] I_ZERO);
  c_auto_run: cover property (O_AUTO_ASK && I_KEY_ENTER ##1 O_AUTO_RUN);
  c_reply_delay: cover property (I_REQ_END && I_REPLY_SEL == 3'h1);
  c_restore: cover property (O_RESTORE);
endmodule : spc_core

// ### spc_pkg.sv
// Shared constants for the scaled pulse counter configuration core.
package spc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int VW = 21;
  localparam logic signed [VW-1:0] VAL_MIN = -21'sd99999;
  localparam logic signed [VW-1:0] VAL_MAX = 21'sd999999;
  localparam logic [2:0] SEL_MULT = 3'h0;
  localparam logic [2:0] SEL_DEN = 3'h1;
  localparam logic [2:0] SEL_OFS = 3'h2;
  localparam logic [2:0] SEL_POINT = 3'h3;
  localparam logic signed [VW-1:0] POINT_MAX = 21'sh00_0005;
  localparam logic signed [VW-1:0] MULT_RST = 21'sh00_0001;
  localparam logic signed [VW-1:0] DEN_RST = 21'sh00_0001;
  localparam logic [7:0] ADDR_MAX = 8'hc7;
  localparam logic [7:0] ADDR_BCAST = 8'hff;
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [7:0] GATE_LO = 8'h04;
  localparam logic [7:0] GATE_HI = 8'h08;
  localparam logic [6:0] GAP_MAX = 7'h63;
  localparam logic [3:0] CHAR_BITS = 4'hb;
  localparam logic [15:0] CODE_OFF = 16'h0000;
  localparam logic [15:0] RESTORE_CODE = 16'h5465;
  localparam logic [3:0] BRIGHT_MIN = 4'h1;
  localparam logic [3:0] BRIGHT_MAX = 4'h8;
  localparam logic [3:0] BRIGHT_RST = 4'h8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_AUTO_ASK = 2'b01,
    ST_AUTO_RUN = 2'b10,
    ST_DEF_ASK = 2'b11
  } spc_state_t;
endpackage : spc_pkg

// ### spc_mb_master.sv
// Behavioural serial-link master that delivers frame, write and request-end events.
`timescale 1ns/10ps
module spc_mb_master #(
  parameter int GAP_CYCLES = 0
) (
  input wire logic i_clk,
  output logic o_frame_valid,
  output logic [7:0] o_frame_addr,
  output logic o_rw_req,
  output logic [7:0] o_rw_reg,
  output logic o_req_end
);
  initial begin
    o_frame_valid = 1'b0;
    o_frame_addr = 8'h00;
    o_rw_req = 1'b0;
    o_rw_reg = 8'h00;
    o_req_end = 1'b0;
  end

  // Released lines show the inverse of their last value, so a stale match cannot pass.
  task automatic frame(input logic [7:0] a);
    @(negedge i_clk);
    o_frame_valid = 1'b1;
    o_frame_addr = a;
    @(negedge i_clk);
    o_frame_valid = 1'b0;
    o_frame_addr = ~a;
    repeat (GAP_CYCLES) @(negedge i_clk);
  endtask : frame

  task automatic wreq(input logic [7:0] r);
    @(negedge i_clk);
    o_rw_req = 1'b1;
    o_rw_reg = r;
    @(negedge i_clk);
    o_rw_req = 1'b0;
    o_rw_reg = ~r;
    repeat (GAP_CYCLES) @(negedge i_clk);
  endtask : wreq

  task automatic req_end();
    @(negedge i_clk);
    o_req_end = 1'b1;
    @(negedge i_clk);
    o_req_end = 1'b0;
    repeat (GAP_CYCLES) @(negedge i_clk);
  endtask : req_end
endmodule : spc_mb_master

// ### tb.sv
// Self-checking bench for the scaled pulse counter configuration core.
`timescale 1ns/10ps
module tb;
  localparam int Z = 0, AW = 1, CW = 2, CT = 3, RT = 4, MX = 5, BW = 6, AS = 7;
  localparam int AD = 8, EN = 9, ES = 10, EW = 11;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] pls = 12'h000;
  logic up = 1'b0, dn = 1'b0, defer = 1'b0, gate = 1'b0, ofs_p = 1'b0;
  logic [2:0] esel = 3'h0, baud = 3'h0, rsel = 3'h0;
  logic signed [20:0] eval = 21'sh00_0000;
  logic [7:0] aval = 8'h01;
  logic [6:0] glim = 7'h00;
  logic [15:0] cval = 16'h0000;
  logic [3:0] thr_p = 4'h0, bval = 4'h8;
  logic fv, rq, re;
  logic [7:0] fa, rr, addr;
  logic signed [55:0] res;
  logic [20:0] pre;
  logic signed [31:0] mainc;
  logic [2:0] point;
  logic [83:0] thr;
  logic [16:0] bitc;
  logic [3:0] tok, bright;
  logic rej, hit, allow, gto, rgo, mok, unl, rused, oeok, qv, aask, arun, rask, rst_p;
  int fails = 0;
  int compares = 0;
  int rate[8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  int ts[12] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 3, 3};
  int tv[12] = '{0, 1000000, -100000, -99999, 999999, 0, 999999, 1, -100000, -99999, 6, 5};
  int tr[12] = '{1, 1, 1, 0, 0, 1, 0, 0, 1, 0, 1, 0};

  // A short second keeps the frame-gap supervision inside a brief run.
  spc_core #(.SEC_CYCLES(10), .RECOVERY_CODE(16'h1234)) dut (
    .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_PULSE_UP(up), .I_PULSE_DN(dn), .I_ZERO(pls[Z]),
    .I_POLICY_DEFER(defer), .I_EDIT_WE(pls[EW]), .I_EDIT_SEL(esel), .I_EDIT_VAL(eval),
    .I_ADDR_WE(pls[AW]), .I_ADDR_VAL(aval), .I_FRAME_VALID(fv), .I_FRAME_ADDR(fa),
    .I_BAUD_SEL(baud), .I_RW_GATE(gate), .I_RW_REQ(rq), .I_RW_REG(rr), .I_GAP_LIMIT(glim),
    .I_REPLY_SEL(rsel), .I_REQ_END(re), .I_CODE_WE(pls[CW]), .I_CODE_TRY(pls[CT]),
    .I_RESTORE_TRY(pls[RT]), .I_CODE_VAL(cval), .I_MENU_EXIT(pls[MX]), .I_THR_PERMIT(thr_p),
    .I_OFS_PERMIT(ofs_p), .I_BRIGHT_WE(pls[BW]), .I_BRIGHT_VAL(bval), .I_AUTO_SEL(pls[AS]),
    .I_AUTO_DONE(pls[AD]), .I_KEY_ENTER(pls[EN]), .I_KEY_ESC(pls[ES]), .O_RESULT(res),
    .O_PRECOUNT(pre), .O_MAINCOUNT(mainc), .O_POINT(point), .O_THRESH(thr), .O_EDIT_REJ(rej),
    .O_ADDR(addr), .O_ADDR_HIT(hit), .O_BIT_CYCLES(bitc), .O_RW_ALLOW(allow),
    .O_GAP_TIMEOUT(gto), .O_REPLY_GO(rgo), .O_MENU_OK(mok), .O_UNLOCKED(unl),
    .O_RECOVERY_USED(rused), .O_THR_EDIT_OK(tok), .O_OFS_EDIT_OK(oeok), .O_QUICKVIEW_ALT(qv),
    .O_BRIGHT(bright), .O_AUTO_ASK(aask), .O_AUTO_RUN(arun), .O_RESTORE_ASK(rask),
    .O_RESTORE(rst_p));
  spc_mb_master m (.i_clk(clk), .o_frame_valid(fv), .o_frame_addr(fa),
    .o_rw_req(rq), .o_rw_reg(rr), .o_req_end(re));

  always #5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // The leading wait keeps two pulses from touching the same line in one time step.
  task automatic pulse(input int b);
    cyc(1);
    pls[b] = 1'b1;
    cyc(1);
    pls = 12'h000;
  endtask : pulse

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic edit(input logic [2:0] s, input int v, input logic r);
    esel = s;
    eval = 21'(v);
    pulse(EW);
    chk(rej, r);
  endtask : edit

  task automatic note(input string s);
    $display("test %s finished, %0d compares", s, compares);
  endtask : note

  function automatic longint fdiv(input longint a, input longint b);
    longint q;
    q = a / b;
    if ((a % b != 0) && ((a < 0) != (b < 0))) q--;
    return q;
  endfunction : fdiv

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #1_000_000;
    fails++;
    print_verdict();
  end

  initial begin
    longint mu, of, mn, net, prev, pthr;
    int de, r, n;
    logic seen;
    logic [15:0] pc;
    void'($urandom(92210));
    cyc(6);
    arst_n = 1'b1;
    chk(addr, 8'h01);
    chk(bright, 4'h8);
    for (int i = 0; i < 12; i++) edit(3'(ts[i]), tv[i], tr[i][0]);
    chk(point, 3'h5);
    edit(3'h2, 42, 1'b0);
    cyc(1);
    chk(res, 42);
    edit(3'h4, 777, 1'b0);
    chk(thr[20:0], 777);
    note("edits");
    for (int run = 0; run < 3; run++) begin
      pulse(Z);
      mu = longint'($urandom_range(1099998)) - 99999;
      if (mu == 0) mu = 1;
      de = (run == 0) ? 1 : int'($urandom_range(9, 2));
      of = longint'($urandom_range(1099998)) - 99999;
      edit(3'h0, int'(mu), 1'b0);
      edit(3'h1, de, 1'b0);
      edit(3'h2, int'(of), 1'b0);
      net = 0;
      for (int k = 0; k < 40; k++) begin
        r = int'($urandom_range(3));
        up = (r != 0);
        dn = (r == 0 || r == 3);
        net += (r == 0) ? -1 : (r == 3) ? 0 : 1;
        cyc(1);
      end
      up = 1'b0;
      dn = 1'b0;
      cyc(2);
      mn = fdiv(net, de);
      chk(mainc, mn);
      chk(pre, net - mn * de);
      chk(res, mn * mu + fdiv((net - mn * de) * mu, de) + of);
    end
    prev = res;
    pthr = thr[83:63];
    defer = 1'b1;
    edit(3'h2, 7, 1'b0);
    edit(3'h7, 123, 1'b0);
    cyc(2);
    chk(res, prev);
    chk(thr[83:63], pthr);
    pulse(Z);
    chk(thr[83:63], 123);
    cyc(1);
    chk(res, 7);
    defer = 1'b0;
    note("counting");
    for (int i = 0; i < 8; i++) begin
      baud = 3'(i);
      cyc(2);
      chk(bitc, 100_000_000 / rate[i]);
    end
    aval = 8'h00;
    pulse(AW);
    m.frame(8'hff);
    chk(hit, 1'b1);
    m.frame(8'h00);
    chk(hit, 1'b0);
    aval = 8'hc8;
    pulse(AW);
    aval = 8'hc7;
    cyc(1);
    chk(addr, 8'h00);
    pulse(AW);
    m.frame(8'hc7);
    chk(hit, 1'b1);
    aval = 8'($urandom_range(199, 1));
    pulse(AW);
    m.frame(aval);
    chk(hit, 1'b1);
    for (int g = 0; g < 2; g++) begin
      gate = g[0];
      for (int k = 2; k < 11; k++) begin
        m.wreq(8'(k));
        chk(allow, (g == 1) || (k >= 4 && k <= 8));
      end
    end
    glim = 7'($urandom_range(3, 1));
    m.frame(8'h01);
    n = 0;
    while (gto !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    if (n >= 60) begin
      fails++;
      print_verdict();
    end
    chk(n >= glim * 10 - 2 && n <= glim * 10 + 4, 1'b1);
    glim = 7'h00;
    m.frame(8'h01);
    cyc(40);
    chk(gto, 1'b0);
    m.req_end();
    chk(rgo, 1'b1);
    rsel = 3'($urandom_range(5, 1));
    m.req_end();
    seen = 1'b0;
    repeat (300) begin
      cyc(1);
      seen |= rgo;
    end
    chk(seen, 1'b0);
    rsel = 3'h0;
    m.req_end();
    chk(rgo, 1'b1);
    note("link");
    thr_p = 4'($urandom);
    ofs_p = 1'($urandom);
    cyc(2);
    chk(tok, thr_p);
    chk({oeok, qv}, {ofs_p, ofs_p});
    cval = 16'h9999;
    pulse(CT);
    chk(mok, 1'b1);
    pc = {4'h4, 12'($urandom)};
    cval = pc;
    pulse(CW);
    chk(unl, 1'b1);
    chk(tok, 4'hf);
    chk(oeok, 1'b1);
    pulse(MX);
    chk(unl, 1'b0);
    cval = 16'h1111;
    pulse(CT);
    chk(mok, 1'b0);
    cval = pc;
    pulse(CT);
    chk(mok, 1'b1);
    pulse(MX);
    cval = 16'h1234;
    pulse(CT);
    chk(mok, 1'b1);
    cval = 16'h2222;
    pulse(CW);
    chk(rused, 1'b1);
    pulse(MX);
    cval = 16'h1234;
    pulse(CT);
    chk(mok, 1'b0);
    note("security");
    bval = 4'h0;
    pulse(BW);
    bval = 4'h9;
    pulse(BW);
    chk(bright, 4'h8);
    bval = 4'h3;
    pulse(BW);
    chk(bright, 4'h3);
    bval = 4'($urandom_range(8, 1));
    pulse(BW);
    chk(bright, bval);
    pulse(AS);
    chk(aask, 1'b1);
    pulse(ES);
    chk({aask, arun}, 2'b00);
    pulse(AS);
    pulse(EN);
    chk(arun, 1'b1);
    pulse(ES);
    chk(arun, 1'b0);
    pulse(AS);
    pulse(EN);
    pulse(AD);
    chk({aask, arun}, 2'b00);
    cval = 16'h5464;
    pulse(RT);
    chk(rask, 1'b0);
    cval = 16'h5465;
    pulse(RT);
    chk(rask, 1'b1);
    pulse(ES);
    chk(rask, 1'b0);
    pulse(RT);
    pulse(EN);
    seen = rst_p;
    cyc(1);
    seen |= rst_p;
    chk(seen, 1'b1);
    chk(bright, 4'h8);
    pulse(CT);
    chk(mok, 1'b1);
    // A second reset in mid-run must bring back the power-up settings.
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    chk(addr, 8'h01);
    chk(rused, 1'b0);
    chk(res, 0);
    cyc(2);
    chk(bitc, 100_000_000 / rate[baud]);
    note("panel");
    print_verdict();
  end
endmodule : tb
